// File: core/gpb_regs.svh
// Purpose: Constants for the parallel instrument bus port
// Assumes: Byte codes are the 7-bit command value after removing low-true sense
// Notes:   Definitions only
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH

`define GPB_DATA_W        8
`define GPB_CODE_W        7
`define GPB_ADDR_W        5
`define GPB_LISTEN_BASE   7'h20
`define GPB_TALK_BASE     7'h40
`define GPB_SEC_BASE      7'h60
`define GPB_GROUP_MASK    7'h60
`define GPB_CMD_UNLISTEN  7'h3f
`define GPB_CMD_UNTALK    7'h5f
`define GPB_CLK_PERIOD_NS 4
`define GPB_SETTLE_NS     100
`define GPB_SETTLE_CYC    ((`GPB_SETTLE_NS + `GPB_CLK_PERIOD_NS - 1) / `GPB_CLK_PERIOD_NS)
`define GPB_PIN_COUNT     15
`define GPB_PIN_IDLE      15'h7fff

`endif

// File: core/gpb_pkg.sv
// Purpose: Types shared by the bus port files
// Assumes: Nothing beyond the constants header
// Notes:   State sets only
package gpb_pkg;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READY,
    ACC_DONE
  } gpb_acc_state_type;

  typedef enum logic [2:0] {
    SRC_IDLE,
    SRC_SETTLE,
    SRC_WAIT,
    SRC_VALID,
    SRC_RELEASE
  } gpb_src_state_type;

endpackage

// File: core/gpb_sync.sv
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Each bit is an independent level
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module gpb_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_r      <= IDLE[i];
          sync_out[i] <= IDLE[i];
        end else begin
          meta_r      <= async_in[i];
          sync_out[i] <= meta_r;
        end
      end
    end
  endgenerate
endmodule

// File: core/gpb_buf2.sv
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock
// Notes:   Output word is held in a flop-based array
`timescale 1ns/1ps
module gpb_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_r;
  logic [PW-1:0]    rd_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_r    <= '0;
      rd_r    <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// File: core/gpb_port.sv
// Purpose: Instrument-side port for the interlocked byte bus: acceptor, source, addressing
// Assumes: Pins open-drain but DIO drives both levels; DIO, DAV, NRFD, NDAC, EOI as input, output and output enable; ATN, IFC, REN input only; SRQ output only
// Notes:   Single 250 MHz clock; all pin inputs pass two flops first
//
// Operation
// - All bus lines low means true
// - Eight low-true data lines, byte per cycle
// - Source drives DAV; acceptors drive NRFD, NDAC
// - Source waits NRFD high, NDAC low first
// - Handshake lines stable 100ns after ATN
// - Source pulls DAV low when ready
// - Acceptor pulls NRFD, releases NDAC after taking
// - Accepted byte: source releases data and DAV
// - DAV released: listener releases NRFD again
// - No fixed rate; steps wait on peer
// - ATN level selects command or data meaning
// - Primary address is 0 to 31
// - Listen address is primary OR 20h
// - Talk address is primary OR 40h
// - Secondary addresses 60h-7Fh are ignored
// - One talker, many listeners
// - Talker sends response bytes one per cycle
// - EOI marks the final byte
// - SRQ held until serviced
// - REN true puts device in remote
// - IFC clears interface state
// - IFC idles talk and listen functions
// - Unlisten command idles the listener
// - Untalk command idles the talker
`timescale 1ns/1ps
`include "gpb_regs.svh"
module gpb_port #(
  parameter int SETTLE_CYC = `GPB_SETTLE_CYC,
  parameter int RX_DEPTH   = 2
) (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic [`GPB_ADDR_W-1:0]  primary_addr,
  input  wire logic [`GPB_DATA_W-1:0]  dio_n_i,
  output logic      [`GPB_DATA_W-1:0]  dio_n_o,
  output logic                         dio_n_oe,
  input  wire logic                    dav_n_i,
  output logic                         dav_n_o,
  output logic                         dav_n_oe,
  input  wire logic                    nrfd_n_i,
  output logic                         nrfd_n_o,
  output logic                         nrfd_n_oe,
  input  wire logic                    ndac_n_i,
  output logic                         ndac_n_o,
  output logic                         ndac_n_oe,
  input  wire logic                    eoi_n_i,
  output logic                         eoi_n_o,
  output logic                         eoi_n_oe,
  input  wire logic                    atn_n_i,
  input  wire logic                    ifc_n_i,
  input  wire logic                    ren_n_i,
  output logic                         srq_n_o,
  output logic                         srq_n_oe,
  input  wire logic [`GPB_DATA_W-1:0]  tx_data,
  input  wire logic                    tx_eoi,
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  output logic      [`GPB_DATA_W-1:0]  rx_data,
  output logic                         rx_eoi,
  output logic                         rx_valid,
  input  wire logic                    rx_ready,
  input  wire logic                    srq_set,
  input  wire logic                    srq_clear,
  output logic                         talk_active,
  output logic                         listen_active,
  output logic                         remote_mode
);
  import gpb_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC + 1);

  // Helpers used by both command decoding and group tests
  function automatic logic [`GPB_CODE_W-1:0] cmd_code(input logic [`GPB_DATA_W-1:0] b);
    cmd_code = b[`GPB_CODE_W-1:0];
  endfunction

  function automatic logic in_group(input logic [`GPB_CODE_W-1:0] c,
                                    input logic [`GPB_CODE_W-1:0] base);
    in_group = ((c & `GPB_GROUP_MASK) == base);
  endfunction

  // Reset release
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Pin synchronisation
  logic [`GPB_PIN_COUNT-1:0] pins_async;
  logic [`GPB_PIN_COUNT-1:0] pins_s;
  assign pins_async = {ren_n_i, ifc_n_i, atn_n_i, eoi_n_i, ndac_n_i, nrfd_n_i, dav_n_i, dio_n_i};

  gpb_sync #(
    .WIDTH (`GPB_PIN_COUNT),
    .IDLE  (`GPB_PIN_IDLE)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (pins_async),
    .sync_out (pins_s)
  );

  // True-sense copies of the synchronised lines
  logic [`GPB_DATA_W-1:0] bus_byte;
  logic dav_t;
  logic nrfd_t;
  logic ndac_t;
  logic eoi_t;
  logic atn_t;
  logic ifc_t;
  logic ren_t;
  assign bus_byte = ~pins_s[7:0];
  assign dav_t    = ~pins_s[8];
  assign nrfd_t   = ~pins_s[9];
  assign ndac_t   = ~pins_s[10];
  assign eoi_t    = ~pins_s[11];
  assign atn_t    = ~pins_s[12];
  assign ifc_t    = ~pins_s[13];
  assign ren_t    = ~pins_s[14];

  // Address derivation
  logic [`GPB_CODE_W-1:0] my_listen;
  logic [`GPB_CODE_W-1:0] my_talk;
  assign my_listen = `GPB_LISTEN_BASE | {2'b00, primary_addr};
  assign my_talk   = `GPB_TALK_BASE | {2'b00, primary_addr};

  // Acceptor
  gpb_acc_state_type acc_r;
  logic              acc_active;
  logic              can_take;
  logic              take;
  logic              buf_in_ready;
  logic              cmd_take;
  logic              data_take;
  logic [`GPB_CODE_W-1:0] code;

  // Every device accepts while ATN is true; data only while listening
  assign acc_active = atn_t || listen_active;
  // Commands never stall; data stalls when the buffer is full
  assign can_take   = atn_t || buf_in_ready;
  assign take       = (acc_r == ACC_READY) && acc_active && can_take && dav_t;
  assign cmd_take   = take && atn_t;
  assign data_take  = take && !atn_t;
  assign code       = cmd_code(bus_byte);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= ACC_IDLE;
    end else if (!acc_active || ifc_t) begin
      acc_r <= ACC_IDLE;
    end else begin
      unique case (acc_r)
        ACC_IDLE:  acc_r <= ACC_READY;
        ACC_READY: begin
          if (take) begin
            acc_r <= ACC_DONE;
          end
        end
        ACC_DONE:  begin
          if (!dav_t) begin
            acc_r <= ACC_READY;
          end
        end
      endcase
    end
  end

  // NDAC held low until taken; NRFD low while not ready or after taking
  logic nrfd_pull;
  logic ndac_pull;
  always_comb begin
    nrfd_pull = 1'b0;
    ndac_pull = 1'b0;
    unique case (acc_r)
      ACC_IDLE:  begin
        nrfd_pull = 1'b0;
        ndac_pull = 1'b0;
      end
      ACC_READY: begin
        nrfd_pull = !can_take;
        ndac_pull = 1'b1;
      end
      ACC_DONE:  begin
        nrfd_pull = 1'b1;
        ndac_pull = 1'b0;
      end
    endcase
  end
  assign nrfd_n_o  = 1'b0;
  assign ndac_n_o  = 1'b0;
  assign nrfd_n_oe = nrfd_pull;
  assign ndac_n_oe = ndac_pull;

  // Addressing state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      listen_active <= 1'b0;
    end else if (ifc_t) begin
      listen_active <= 1'b0;
    end else if (cmd_take) begin
      if (code == `GPB_CMD_UNLISTEN) begin
        listen_active <= 1'b0;
      end else if (code == my_listen) begin
        listen_active <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      talk_active <= 1'b0;
    end else if (ifc_t) begin
      talk_active <= 1'b0;
    end else if (cmd_take) begin
      if (code == `GPB_CMD_UNTALK) begin
        talk_active <= 1'b0;
      end else if (code == my_talk) begin
        talk_active <= 1'b1;
      end else if (in_group(code, `GPB_TALK_BASE)) begin
        talk_active <= 1'b0;
      end
      // Secondary group codes fall through untouched
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      remote_mode <= 1'b0;
    end else begin
      remote_mode <= ren_t;
    end
  end

  // Received data path
  gpb_buf2 #(
    .WIDTH (`GPB_DATA_W + 1),
    .DEPTH (RX_DEPTH)
  ) u_rx_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_data   ({eoi_t, bus_byte}),
    .in_valid  (data_take),
    .in_ready  (buf_in_ready),
    .out_data  ({rx_eoi, rx_data}),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // Source
  gpb_src_state_type src_r;
  logic [CW-1:0]     settle_r;
  logic              src_ok;
  logic [`GPB_DATA_W-1:0] out_byte_r;
  logic              out_eoi_r;
  logic              drive_r;

  // A source may only run while talking with ATN false
  assign src_ok   = talk_active && !atn_t && !ifc_t;
  assign tx_ready = (src_r == SRC_IDLE) && src_ok;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_r    <= SRC_IDLE;
      settle_r <= '0;
    end else if (!src_ok) begin
      // Losing talk or ATN going true drops the byte at once
      src_r    <= SRC_IDLE;
      settle_r <= '0;
    end else begin
      unique case (src_r)
        SRC_IDLE: begin
          if (tx_valid) begin
            src_r    <= SRC_SETTLE;
            settle_r <= CW'(SETTLE_CYC);
          end
        end
        SRC_SETTLE: begin
          // Data settles before DAV; also spaces DAV from an ATN change
          if (settle_r <= CW'(1)) begin
            src_r <= SRC_WAIT;
          end
          settle_r <= settle_r - 1'b1;
        end
        SRC_WAIT: begin
          if (!nrfd_t && ndac_t) begin
            src_r <= SRC_VALID;
          end
        end
        SRC_VALID: begin
          if (!ndac_t) begin
            src_r <= SRC_RELEASE;
          end
        end
        SRC_RELEASE: begin
          // Next byte only after the acceptors return NDAC low
          if (ndac_t) begin
            src_r <= SRC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_byte_r <= '0;
      out_eoi_r  <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      out_byte_r <= tx_data;
      out_eoi_r  <= tx_eoi;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= src_ok && (src_r == SRC_SETTLE || src_r == SRC_WAIT || src_r == SRC_VALID);
    end
  end

  assign dio_n_o  = ~out_byte_r;
  assign dio_n_oe = drive_r;
  assign dav_n_o  = 1'b0;
  assign dav_n_oe = src_ok && (src_r == SRC_VALID);
  assign eoi_n_o  = 1'b0;
  assign eoi_n_oe = src_ok && (src_r == SRC_VALID) && out_eoi_r;

  // Service request, set wins over clear
  logic srq_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      srq_r <= 1'b0;
    end else if (srq_set) begin
      srq_r <= 1'b1;
    end else if (srq_clear) begin
      srq_r <= 1'b0;
    end
  end
  assign srq_n_o  = 1'b0;
  assign srq_n_oe = srq_r;

endmodule

// File: sim/gpb_port_assertions.sv
// Purpose: Port-level checks for the bus port
// Assumes: Bound to gpb_port, pins sampled on the system clock
// Notes:   Windows allow for the two-flop pin synchronisers
`timescale 1ns/1ps
module gpb_port_checker #(
  parameter int SETTLE_CYC = 25,
  parameter int RX_DEPTH   = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic dio_n_oe,
  input wire logic dav_n_i,
  input wire logic dav_n_oe,
  input wire logic nrfd_n_i,
  input wire logic nrfd_n_oe,
  input wire logic ndac_n_i,
  input wire logic ndac_n_oe,
  input wire logic eoi_n_oe,
  input wire logic atn_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  input wire logic srq_n_oe,
  input wire logic srq_set,
  input wire logic srq_clear,
  input wire logic tx_ready,
  input wire logic talk_active,
  input wire logic listen_active,
  input wire logic remote_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_reset_quiet: assert property (disable iff (1'b0) !rstn |->
    !(dio_n_oe | dav_n_oe | nrfd_n_oe | ndac_n_oe | srq_n_oe)) else $error("line driven in reset");
  a_dav_ready: assert property ($rose(dav_n_oe) |-> $past(nrfd_n_i, 3) && !$past(ndac_n_i, 3))
    else $error("valid before ready");
  a_data_dav: assert property (dav_n_oe |-> dio_n_oe) else $error("valid without data");
  a_eoi_dav: assert property (eoi_n_oe |-> dav_n_oe) else $error("end mark without valid");
  a_dav_drop: assert property ($rose(ndac_n_i) && dav_n_oe |-> ##[1:4] !dav_n_oe)
    else $error("valid kept after accept");
  a_accept_byte: assert property ($fell(dav_n_i) && !atn_n_i && !nrfd_n_oe |->
    ##[1:5] nrfd_n_oe && !ndac_n_oe) else $error("byte not accepted");
  a_ready_again: assert property ($rose(dav_n_i) && ndac_n_i && !atn_n_i |->
    ##[1:5] ndac_n_oe && !nrfd_n_oe) else $error("not ready again");
  a_ifc_idle: assert property ($fell(ifc_n_i) |-> ##[2:5] !talk_active && !listen_active)
    else $error("clear ignored");
  a_remote_on: assert property (!ren_n_i [*5] |-> remote_mode) else $error("remote missed");
  a_atn_quiet: assert property (!atn_n_i [*4] |-> !tx_ready && !dav_n_oe)
    else $error("talking under attention");
  a_srq_set: assert property (srq_set |=> srq_n_oe) else $error("request not raised");
  a_srq_hold: assert property (srq_n_oe && !srq_clear |=> srq_n_oe) else $error("request dropped");
endmodule

bind gpb_port gpb_port_checker #(.SETTLE_CYC(SETTLE_CYC), .RX_DEPTH(RX_DEPTH)) i_gpb_port_checker (
  .clock, .rstn, .dio_n_oe, .dav_n_i, .dav_n_oe, .nrfd_n_i, .nrfd_n_oe, .ndac_n_i, .ndac_n_oe,
  .eoi_n_oe, .atn_n_i, .ifc_n_i, .ren_n_i, .srq_n_oe, .srq_set, .srq_clear, .tx_ready,
  .talk_active, .listen_active, .remote_mode
);

// File: sim/gpb_ctl_model.sv
// Purpose: Behavioural bus controller for the port bench
// Assumes: Wired lines pulled up; enables high pull a line low
// Notes:   Waits are unbounded; the bench timeout cuts a hang
`timescale 1ns/1ps
module gpb_ctl_model (
  input  wire logic       clock,
  input  wire logic [7:0] dio_n,
  input  wire logic       dav_n,
  input  wire logic       nrfd_n,
  input  wire logic       ndac_n,
  input  wire logic       eoi_n,
  output logic            atn_n,
  output logic      [7:0] dio_o,
  output logic            dio_oe,
  output logic            dav_oe,
  output logic            nrfd_oe,
  output logic            ndac_oe,
  output logic            eoi_oe
);
  initial begin
    atn_n = 1'b1;
    dio_o = 8'hff;
    {dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe} = 5'h00;
  end

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // Source side; low level on every line means true
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    step();
    {nrfd_oe, ndac_oe} = 2'b00;
    atn_n = !atn;
    dio_o = ~b;
    dio_oe = 1'b1;
    eoi_oe = eoi;
    repeat (30) step(); // Longer than 100ns after attention
    while (!nrfd_n || ndac_n) step();
    dav_oe = 1'b1;
    while (!ndac_n) step();
    {dav_oe, dio_oe, eoi_oe} = 3'b000;
    dio_o = 8'hff;
    while (ndac_n) step();
  endtask

  // Release attention so the addressed talker may run
  task automatic idle();
    step();
    atn_n = 1'b1;
  endtask

  // Slow acceptor: holds off four cycles before ready
  task automatic recv(output logic [7:0] b, output logic e);
    step();
    {nrfd_oe, ndac_oe} = 2'b11;
    repeat (4) step();
    nrfd_oe = 1'b0;
    while (dav_n) step();
    b = ~dio_n;
    e = !eoi_n;
    {nrfd_oe, ndac_oe} = 2'b10;
    while (!dav_n) step();
    {nrfd_oe, ndac_oe} = 2'b01;
  endtask
endmodule

// File: sim/tb_gpb_port.sv
// Purpose: Self-checking bench for the bus port
// Assumes: Controller model on the far side of wired, pulled-up lines
// Notes:   A short settle count keeps the run brief
`timescale 1ns/1ps
module tb_gpb_port;
  logic       clock, rstn, ifc_n, ren_n;
  logic [4:0] paddr;
  logic [7:0] tx_data, rx_data, dio_o, m_dio;
  logic       tx_eoi, tx_valid, tx_ready, rx_eoi, rx_valid, rx_ready;
  logic       srq_set, srq_clear, srq_oe, talk, listen, remote;
  logic       dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe;
  logic       dav_o, nrfd_o, ndac_o, eoi_o, srq_o;
  logic       m_atn_n, m_dio_oe, m_dav, m_nrfd, m_ndac, m_eoi;
  int         mismatches, check_count, cyc;
  wire  [7:0] dio_w  = (dio_oe ? dio_o : 8'hff) & (m_dio_oe ? m_dio : 8'hff);
  // Pulled-up lines: a driven line shows the level the port puts out
  wire        dav_w  = (dav_oe ? dav_o : 1'b1) & !m_dav;
  wire        nrfd_w = (nrfd_oe ? nrfd_o : 1'b1) & !m_nrfd;
  wire        ndac_w = (ndac_oe ? ndac_o : 1'b1) & !m_ndac;
  wire        eoi_w  = (eoi_oe ? eoi_o : 1'b1) & !m_eoi;
  wire        srq_w  = srq_oe ? srq_o : 1'b1;

  gpb_port #(.SETTLE_CYC(3), .RX_DEPTH(2)) i_gpb_port (
    .clock, .rstn, .primary_addr(paddr), .dio_n_i(dio_w), .dio_n_o(dio_o), .dio_n_oe(dio_oe),
    .dav_n_i(dav_w), .dav_n_o(dav_o), .dav_n_oe(dav_oe), .nrfd_n_i(nrfd_w), .nrfd_n_o(nrfd_o), .nrfd_n_oe(nrfd_oe),
    .ndac_n_i(ndac_w), .ndac_n_o(ndac_o), .ndac_n_oe(ndac_oe), .eoi_n_i(eoi_w), .eoi_n_o(eoi_o), .eoi_n_oe(eoi_oe),
    .atn_n_i(m_atn_n), .ifc_n_i(ifc_n), .ren_n_i(ren_n), .srq_n_o(srq_o), .srq_n_oe(srq_oe),
    .tx_data, .tx_eoi, .tx_valid, .tx_ready, .rx_data, .rx_eoi, .rx_valid, .rx_ready, .srq_set,
    .srq_clear, .talk_active(talk), .listen_active(listen), .remote_mode(remote)
  );

  gpb_ctl_model i_gpb_ctl_model (
    .clock, .dio_n(dio_w), .dav_n(dav_w), .nrfd_n(nrfd_w), .ndac_n(ndac_w), .eoi_n(eoi_w),
    .atn_n(m_atn_n), .dio_o(m_dio), .dio_oe(m_dio_oe), .dav_oe(m_dav), .nrfd_oe(m_nrfd),
    .ndac_oe(m_ndac), .eoi_oe(m_eoi)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    i_gpb_ctl_model.send(b, 1'b1, 1'b0);
    repeat (3) step();
  endtask

  task automatic tx_send(input logic [7:0] d, input logic e);
    step();
    tx_data = d;
    tx_eoi = e;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) step();
    step();
    tx_valid = 1'b0;
  endtask

  // Addressing, then fill the receive buffer until refused and drain it
  task automatic t_listen_fill();
    cmd(8'h37);
    chk(listen, 1'b0);
    cmd(8'h36);
    chk(listen, 1'b1);
    rx_ready = 1'b0;
    i_gpb_ctl_model.send(8'ha5, 1'b0, 1'b0);
    i_gpb_ctl_model.send(8'h5a, 1'b0, 1'b1);
    repeat (8) step();
    chk(nrfd_oe, 1'b1);
    chk(rx_valid, 1'b1);
    chk(rx_data, 8'ha5);
    chk(rx_eoi, 1'b0);
    rx_ready = 1'b1;
    step();
    chk(rx_data, 8'h5a);
    chk(rx_eoi, 1'b1);
    step();
    rx_ready = 1'b0;
    chk(rx_valid, 1'b0);
    repeat (4) step();
    chk(nrfd_oe, 1'b0);
    cmd(8'h60);
    cmd(8'h7f);
    chk(listen, 1'b1);
    cmd(8'h3f);
    chk(listen, 1'b0);
    rx_ready = 1'b1;
  endtask

  // Talk two bytes to a slow acceptor, then untalk
  task automatic t_talk();
    logic [7:0] b;
    logic       e;
    cmd(8'h56);
    i_gpb_ctl_model.idle();
    repeat (4) step();
    chk(talk, 1'b1);
    fork
      begin
        tx_send(8'hc3, 1'b0);
        tx_send(8'h3c, 1'b1);
      end
      begin
        i_gpb_ctl_model.recv(b, e);
        chk(b, 8'hc3);
        chk(e, 1'b0);
        i_gpb_ctl_model.recv(b, e);
        chk(b, 8'h3c);
        chk(e, 1'b1);
      end
    join
    cmd(8'h5f);
    chk(talk, 1'b0);
  endtask

  task automatic t_ifc();
    cmd(8'h36);
    cmd(8'h56);
    ifc_n = 1'b0;
    repeat (6) step();
    chk(listen, 1'b0);
    chk(talk, 1'b0);
    ifc_n = 1'b1;
  endtask

  // Another primary address; a foreign talk address unaddresses this talker
  task automatic t_addr();
    paddr = 5'h01;
    cmd(8'h21);
    chk(listen, 1'b1);
    cmd(8'h41);
    chk(talk, 1'b1);
    cmd(8'h42);
    chk(talk, 1'b0);
    chk(listen, 1'b1);
    cmd(8'h3f);
    chk(listen, 1'b0);
  endtask

  task automatic t_srq_ren();
    srq_set = 1'b1;
    step();
    srq_set = 1'b0;
    repeat (5) step();
    chk(srq_oe, 1'b1);
    chk(srq_w, 1'b0);
    srq_clear = 1'b1;
    step();
    srq_clear = 1'b0;
    repeat (2) step();
    chk(srq_oe, 1'b0);
    ren_n = 1'b0;
    repeat (6) step();
    chk(remote, 1'b1);
    ren_n = 1'b1;
    repeat (6) step();
    chk(remote, 1'b0);
  endtask

  initial begin
    {rstn, ifc_n, ren_n, paddr} = {3'b111, 5'h16};
    {tx_data, tx_eoi, tx_valid, rx_ready, srq_set, srq_clear} = {8'h00, 5'b00100};
    mismatches = 0;
    check_count = 0;
    // A real falling edge, so the asynchronous resets act before the first clock edge
    #1 rstn = 1'b0;
    repeat (2) step();
    rstn = 1'b1;
    repeat (6) step();
    t_listen_fill();
    t_talk();
    t_ifc();
    t_addr();
    t_srq_ren();
    summarize();
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clock);
      cyc++;
      if (cyc > 20000) begin
        mismatches++;
        summarize();
      end
    end
  end
endmodule
